/* common/fsmd_pkg.sv */
package fsmd_pkg;
    // Clock and measurement timebase
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_HZ = 100_000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int TICK_DIV_W = 8;
    // Update periods in milliseconds and in timebase ticks
    localparam int FAST_RATE_MS = 250;
    localparam int SLOW_RATE_MS = 1000;
    localparam int TICKS_PER_MS = TICK_HZ / 1000;
    localparam int FAST_RATE_TICKS = FAST_RATE_MS * TICKS_PER_MS;
    localparam int SLOW_RATE_TICKS = SLOW_RATE_MS * TICKS_PER_MS;
    // Period counter
    localparam int PERIOD_W = 16;
    localparam logic [15:0] PERIOD_MAX = 16'hFFFF;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    // Speed pulse periods per measurement, by pulses-per-rev select
    localparam logic [2:0] EDGES_TWO_PERIODS = 3'h2;
    localparam logic [2:0] EDGES_FOUR_PERIODS = 3'h4;
    // Duty values, 8 bits with 0xFF meaning 100 %
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [7:0] DUTY_MIN_7PCT = 8'h12;
    localparam logic [7:0] DUTY_MIN_30PCT = 8'h4D;
    localparam logic [7:0] DUTY_SPIN_33PCT = 8'h55;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam int RAMP_STEPS_X3 = 3 * (255 - 85);
    // Spin-up retries before fan failure, and spin-up time code at reset
    localparam logic [2:0] SPIN_FAIL_COUNT = 3'h5;
    localparam logic [2:0] SPINUP_TIME_RESET = 3'h5;
    // Fan control modes
    typedef enum logic [1:0] {
        FSMD_MODE_SW_DUTY = 2'b00,
        FSMD_MODE_SW_RPM = 2'b01,
        FSMD_MODE_AUTO_A = 2'b10,
        FSMD_MODE_AUTO_B = 2'b11
    } fsmd_mode_t;
    // Measurement sequencer states
    typedef enum logic [1:0] {
        FSMD_IDLE = 2'b00,
        FSMD_ARM = 2'b01,
        FSMD_COUNT = 2'b10,
        FSMD_SPIN = 2'b11
    } fsmd_state_t;
    // Spin-up time in milliseconds for each code
    function automatic int fsmd_spin_ms(input logic [2:0] code);
        case (code)
            3'd0: return 200;
            3'd1: return 400;
            3'd2: return 600;
            3'd3: return 800;
            3'd4: return 1000;
            3'd5: return 2000;
            3'd6: return 4000;
            default: return 8000;
        endcase
    endfunction
endpackage

/* core/fsmd_monitor.sv */
`timescale 1ns/1ns
module fsmd_monitor #(
    parameter int FAST_TICKS = fsmd_pkg::FAST_RATE_TICKS,
    parameter int SLOW_TICKS = fsmd_pkg::SLOW_RATE_TICKS,
    parameter int MS_TICKS = fsmd_pkg::TICKS_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic start_bit,
    input wire logic speed_meas_enable,
    input wire logic pulses_per_rev_select,
    input wire logic fast_rate,
    input wire logic fan_power_type,
    input wire fsmd_pkg::fsmd_mode_t fan_mode,
    input wire logic [7:0] duty_cycle_register,
    input wire logic [7:0] calc_duty,
    input wire logic [15:0] min_speed_limit,
    input wire logic [15:0] max_speed_limit,
    input wire logic fan_range_irq_enable,
    input wire logic fault_pin_enable,
    input wire logic spinup_disable,
    input wire logic [2:0] spinup_time_field,
    input wire logic speed_pulse,
    input wire logic period_low_rd,
    input wire logic period_high_rd,
    input wire logic status_rd,
    output logic [7:0] period_low_byte,
    output logic [7:0] period_high_byte,
    output logic fan_slow_flag,
    output logic overspeed_flag,
    output logic fan_failure,
    output logic fan_range_event,
    output logic smb_alert_out,
    output logic smb_alert_oe,
    output logic fault_pin_out,
    output logic fault_pin_oe,
    output logic [7:0] pwm_duty,
    output logic pwm_force_on,
    output logic duty_correct_en
);
    import fsmd_pkg::*;

    fsmd_state_t state_reg;
    logic [TICK_DIV_W-1:0] div_reg;
    logic tick;
    logic [16:0] rate_reg;
    logic rate_due_reg;
    logic pulse_d_reg;
    logic pulse_rise;
    logic [2:0] edge_reg;
    logic [15:0] count_reg;
    logic [15:0] period_reg;
    logic [7:0] hi_hold_reg;
    logic freeze_reg;
    logic slow_reg;
    logic over_reg;
    logic over_armed_reg;
    logic fail_reg;
    logic [2:0] retry_reg;
    logic after_spin_reg;
    logic [19:0] spin_cnt_reg;
    logic [19:0] ramp_cnt_reg;
    logic [7:0] ramp_duty_reg;
    logic monitor_on;
    logic [7:0] base_duty;
    logic skip_update;
    logic meas_done;
    logic [15:0] meas_value;
    logic meas_slow;
    logic [19:0] spin_len;
    logic [19:0] ramp_div;
    logic [2:0] edges_needed;
    logic [16:0] rate_len;

    // Saturating increment of the period counter
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == PERIOD_MAX) ? PERIOD_MAX : v + 16'h0001;
    endfunction

    assign monitor_on = start_bit & speed_meas_enable;
    assign edges_needed = pulses_per_rev_select ? EDGES_FOUR_PERIODS
                                                : EDGES_TWO_PERIODS;
    assign rate_len = fast_rate ? 17'(FAST_TICKS)
                                : 17'(SLOW_TICKS);
    assign spin_len = 20'(fsmd_spin_ms(spinup_time_field)
                          * MS_TICKS);
    assign ramp_div = (spin_len / 20'(RAMP_STEPS_X3) == 20'h0_0000) ?
                      20'h0_0001 : spin_len / 20'(RAMP_STEPS_X3);
    assign pulse_rise = speed_pulse & ~pulse_d_reg;
    assign base_duty = (fan_mode == FSMD_MODE_SW_DUTY) ? duty_cycle_register
                                                       : calc_duty;
    // Low duty on a PWM-powered fan skips the update outside RPM mode
    assign skip_update = ~fan_power_type
                         && fan_mode != FSMD_MODE_SW_RPM
                         && base_duty < DUTY_MIN_7PCT;

    // Measurement ends on the last edge or on over-range
    always_comb begin
        meas_done = 1'b0;
        meas_value = count_reg;
        if (state_reg == FSMD_ARM || state_reg == FSMD_COUNT) begin
            if (count_reg == PERIOD_MAX) begin
                meas_done = 1'b1;
                meas_value = PERIOD_MAX;
            end else if (state_reg == FSMD_COUNT && pulse_rise
                         && edge_reg >= edges_needed - 3'h1) begin
                meas_done = 1'b1;
            end
        end
    end
    assign meas_slow = meas_value > min_speed_limit;

    // 100 kHz timebase from the core clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (clk_en) begin
            if (div_reg == TICK_DIV_W'(TICK_DIV - 1)) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end
    assign tick = clk_en && div_reg == TICK_DIV_W'(TICK_DIV - 1);

    // Update-rate timer raises a request for the next measurement
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg <= '0;
            rate_due_reg <= 1'b0;
        end else if (clk_en) begin
            if (!monitor_on) begin
                rate_reg <= '0;
                rate_due_reg <= 1'b0;
            end else if (tick && rate_reg >= rate_len - 17'h0_0001) begin
                rate_reg <= '0;
                rate_due_reg <= 1'b1;
            end else begin
                if (tick) begin
                    rate_reg <= rate_reg + 17'h0_0001;
                end
                if (state_reg == FSMD_IDLE && rate_due_reg) begin
                    rate_due_reg <= 1'b0;
                end
            end
        end
    end

    // Speed pulse edge detector
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_d_reg <= 1'b0;
        end else if (clk_en) begin
            pulse_d_reg <= speed_pulse;
        end
    end

    // Sequencer: wait, arm, count periods, spin-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= FSMD_IDLE;
            edge_reg <= '0;
            count_reg <= PERIOD_RESET;
        end else if (clk_en) begin
            if (!monitor_on) begin
                state_reg <= FSMD_IDLE;
            end else begin
                unique case (state_reg)
                    FSMD_IDLE: begin
                        if (rate_due_reg
                            && (!skip_update || after_spin_reg)) begin
                            state_reg <= FSMD_ARM;
                            count_reg <= PERIOD_RESET;
                        end
                    end
                    FSMD_ARM: begin
                        if (meas_done) begin
                            state_reg <= FSMD_IDLE;
                        end else if (pulse_rise) begin
                            state_reg <= FSMD_COUNT;
                            edge_reg <= '0;
                            count_reg <= PERIOD_RESET;
                        end else if (tick) begin
                            count_reg <= sat_inc(count_reg);
                        end
                    end
                    FSMD_COUNT: begin
                        if (meas_done) begin
                            state_reg <= FSMD_IDLE;
                        end else begin
                            if (pulse_rise) begin
                                edge_reg <= edge_reg + 3'h1;
                            end
                            if (tick) begin
                                count_reg <= sat_inc(count_reg);
                            end
                        end
                    end
                    FSMD_SPIN: begin
                        if (tick
                            && spin_cnt_reg >= spin_len - 20'h0_0001) begin
                            state_reg <= FSMD_ARM;
                            count_reg <= PERIOD_RESET;
                        end
                    end
                endcase
                if (meas_done && meas_slow && !spinup_disable) begin
                    state_reg <= FSMD_SPIN;
                end
            end
        end
    end

    // Spin-up timer and duty ramp
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spin_cnt_reg <= '0;
            ramp_cnt_reg <= '0;
            ramp_duty_reg <= DUTY_SPIN_33PCT;
        end else if (clk_en) begin
            if (state_reg != FSMD_SPIN) begin
                spin_cnt_reg <= '0;
                ramp_cnt_reg <= '0;
                ramp_duty_reg <= DUTY_SPIN_33PCT;
            end else if (tick) begin
                spin_cnt_reg <= spin_cnt_reg + 20'h0_0001;
                if (ramp_cnt_reg >= ramp_div - 20'h0_0001) begin
                    ramp_cnt_reg <= '0;
                    if (ramp_duty_reg != DUTY_FULL) begin
                        ramp_duty_reg <= ramp_duty_reg + 8'h01;
                    end
                end else begin
                    ramp_cnt_reg <= ramp_cnt_reg + 20'h0_0001;
                end
            end
        end
    end

    // Period register update, skipped at low duty for PWM-powered fans outside RPM mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= PERIOD_RESET;
        end else if (clk_en) begin
            if (meas_done && monitor_on) begin
                period_reg <= meas_value;
            end
        end
    end

    // Two-byte read: low byte read freezes the high byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            freeze_reg <= 1'b0;
            hi_hold_reg <= PERIOD_RESET[15:8];
        end else if (clk_en) begin
            if (period_low_rd) begin
                freeze_reg <= 1'b1;
                hi_hold_reg <= period_reg[15:8];
            end else if (period_high_rd) begin
                freeze_reg <= 1'b0;
            end else if (!freeze_reg) begin
                hi_hold_reg <= period_reg[15:8];
            end
        end
    end
    assign period_low_byte = period_reg[7:0];
    assign period_high_byte = hi_hold_reg;

    // Fan slow flag: set wins over read clear, set at spin-up start but not by the measurement after spin-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_reg <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == FSMD_SPIN && spin_cnt_reg == 20'h0_0000) begin
                slow_reg <= 1'b1;
            end else if (meas_done && meas_slow && !after_spin_reg) begin
                slow_reg <= 1'b1;
            end else if (status_rd) begin
                slow_reg <= 1'b0;
            end
        end
    end

    // Overspeed flag with re-arm once speed drops below maximum
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            over_reg <= 1'b0;
            over_armed_reg <= 1'b1;
        end else if (clk_en) begin
            if (meas_done && meas_value < max_speed_limit
                && over_armed_reg) begin
                over_reg <= 1'b1;
            end else if (status_rd && over_reg) begin
                over_reg <= 1'b0;
                over_armed_reg <= 1'b0;
            end
            if (meas_done && meas_value >= max_speed_limit) begin
                over_armed_reg <= 1'b1;
            end
        end
    end

    // Spin-up retries and failure declaration
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            retry_reg <= '0;
            fail_reg <= 1'b0;
            after_spin_reg <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == FSMD_SPIN && spin_cnt_reg == 20'h0_0000
                && tick) begin
                after_spin_reg <= 1'b1;
                if (retry_reg != SPIN_FAIL_COUNT) begin
                    retry_reg <= retry_reg + 3'h1;
                end
            end
            if (meas_done) begin
                after_spin_reg <= 1'b0;
                if (!meas_slow) begin
                    retry_reg <= '0;
                    fail_reg <= 1'b0;
                end else if (retry_reg == SPIN_FAIL_COUNT) begin
                    fail_reg <= 1'b1;
                end
            end
            if (!monitor_on) begin
                after_spin_reg <= 1'b0;
            end
        end
    end

    // PWM duty selection with forcing and clamping
    always_comb begin
        if (state_reg == FSMD_SPIN) begin
            pwm_duty = ramp_duty_reg;
        end else if (after_spin_reg) begin
            pwm_duty = DUTY_SPIN_33PCT;
        end else if (fan_power_type) begin
            pwm_duty = base_duty;
        end else if (fan_mode == FSMD_MODE_SW_RPM) begin
            pwm_duty = (base_duty < DUTY_MIN_30PCT) ? DUTY_MIN_30PCT
                                                    : base_duty;
        end else begin
            pwm_duty = (base_duty < DUTY_MIN_7PCT) ? DUTY_ZERO
                                                   : base_duty;
        end
    end

    // PWM held on during counting for PWM-powered fans
    assign pwm_force_on = ~fan_power_type
                          && (state_reg == FSMD_ARM
                              || state_reg == FSMD_COUNT);
    assign duty_correct_en = ~fan_power_type;

    // Status outputs, alert and fault pins
    assign fan_slow_flag = slow_reg;
    assign overspeed_flag = over_reg;
    assign fan_failure = fail_reg;
    assign fan_range_event = (slow_reg | over_reg)
                             & fan_range_irq_enable;
    assign smb_alert_out = 1'b0;
    assign smb_alert_oe = fan_range_event;
    assign fault_pin_out = 1'b0;
    assign fault_pin_oe = fail_reg & fault_pin_enable;
endmodule

/* dv/fsmd_fan_model.sv */
`timescale 1ns/1ns
// Fan speed pulse source; a zero half period means a stalled fan
module fsmd_fan_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] half_clks,
    output logic speed_pulse
);
    logic [15:0] cnt_reg;
    // Toggle after each half period, rest low while stalled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
            speed_pulse <= 1'b0;
        end else if (half_clks == 16'h0000) begin
            cnt_reg <= 16'h0000;
            speed_pulse <= 1'b0;
        end else if (cnt_reg >= half_clks - 16'h0001) begin
            cnt_reg <= 16'h0000;
            speed_pulse <= !speed_pulse;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

/* dv/fsmd_monitor_assertions.sv */
`timescale 1ns/1ns
// Port-level checks of the fan speed monitor
module fsmd_monitor_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic start_bit,
    input wire logic speed_meas_enable,
    input wire logic fan_power_type,
    input wire fsmd_pkg::fsmd_mode_t fan_mode,
    input wire logic [7:0] duty_cycle_register,
    input wire logic [7:0] calc_duty,
    input wire logic fan_range_irq_enable,
    input wire logic fault_pin_enable,
    input wire logic spinup_disable,
    input wire logic period_low_rd,
    input wire logic period_high_rd,
    input wire logic [7:0] period_low_byte,
    input wire logic [7:0] period_high_byte,
    input wire logic fan_slow_flag,
    input wire logic overspeed_flag,
    input wire logic fan_failure,
    input wire logic fan_range_event,
    input wire logic smb_alert_out,
    input wire logic smb_alert_oe,
    input wire logic fault_pin_out,
    input wire logic fault_pin_oe,
    input wire logic [7:0] pwm_duty,
    input wire logic pwm_force_on,
    input wire logic duty_correct_en
);
    import fsmd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] base_duty;
    logic hi_frozen_reg;
    // Duty source chosen by the control mode
    assign base_duty = (fan_mode == FSMD_MODE_SW_DUTY) ? duty_cycle_register
                                                      : calc_duty;
    // Tracks the window between a low byte read and the high byte read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_frozen_reg <= 1'b0;
        end else if (clk_en && period_low_rd) begin
            hi_frozen_reg <= 1'b1;
        end else if (clk_en && period_high_rd) begin
            hi_frozen_reg <= 1'b0;
        end
    end
    sequence s_mon_off;
        !start_bit || !speed_meas_enable;
    endsequence
    sequence s_frozen_idle;
        hi_frozen_reg && !period_high_rd && !period_low_rd;
    endsequence
    a_range_event: assert property (fan_range_event ==
        ((fan_slow_flag || overspeed_flag) && fan_range_irq_enable))
        else $error("range event mismatch");
    a_alert_pull_low: assert property (smb_alert_oe == fan_range_event
        && !smb_alert_out) else $error("alert line mismatch");
    a_fault_pin_oe: assert property (fault_pin_oe ==
        (fan_failure && fault_pin_enable)) else $error("fault pin enable");
    a_fault_pin_low: assert property (fault_pin_oe |-> !fault_pin_out)
        else $error("fault pin not low");
    a_correct_enable: assert property (duty_correct_en != fan_power_type)
        else $error("duty correction mismatch");
    a_no_force_dc: assert property (fan_power_type |-> !pwm_force_on)
        else $error("force on with dc fan");
    a_duty_pass: assert property (fan_power_type && spinup_disable &&
        fan_mode == FSMD_MODE_SW_DUTY |-> pwm_duty == duty_cycle_register)
        else $error("duty not passed through");
    a_duty_zeroed: assert property (!fan_power_type && spinup_disable &&
        fan_mode != FSMD_MODE_SW_RPM && base_duty < DUTY_MIN_7PCT
        |-> pwm_duty == DUTY_ZERO) else $error("low duty not zeroed");
    a_duty_clamped: assert property (!fan_power_type && spinup_disable &&
        fan_mode == FSMD_MODE_SW_RPM && calc_duty < DUTY_MIN_30PCT
        |-> pwm_duty == DUTY_MIN_30PCT) else $error("duty not clamped");
    a_high_frozen: assert property (s_frozen_idle
        |=> $stable(period_high_byte)) else $error("high byte moved");
    a_monitor_off: assert property (s_mon_off ##1 s_mon_off
        |-> $stable(period_low_byte)) else $error("period moved while off");
endmodule
bind fsmd_monitor fsmd_monitor_assertions i_fsmd_monitor_assertions (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .start_bit(start_bit), .speed_meas_enable(speed_meas_enable),
    .fan_power_type(fan_power_type), .fan_mode(fan_mode),
    .duty_cycle_register(duty_cycle_register), .calc_duty(calc_duty),
    .fan_range_irq_enable(fan_range_irq_enable),
    .fault_pin_enable(fault_pin_enable), .spinup_disable(spinup_disable),
    .period_low_rd(period_low_rd), .period_high_rd(period_high_rd),
    .period_low_byte(period_low_byte), .period_high_byte(period_high_byte),
    .fan_slow_flag(fan_slow_flag), .overspeed_flag(overspeed_flag),
    .fan_failure(fan_failure), .fan_range_event(fan_range_event),
    .smb_alert_out(smb_alert_out), .smb_alert_oe(smb_alert_oe),
    .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe),
    .pwm_duty(pwm_duty), .pwm_force_on(pwm_force_on),
    .duty_correct_en(duty_correct_en));

/* dv/fsmd_monitor_bench.sv */
`timescale 1ns/1ns
// Self-checking bench with short rate timers
module fsmd_monitor_bench;
    import fsmd_pkg::*;
    localparam int CYC_LIMIT = 80000;
    localparam int SETTLE = 6000;
    logic core_clk, rst_n, clk_en, start_bit, speed_meas_enable, pps;
    logic fast_rate, fan_power_type, irq_en, fault_en, spin_dis, pulse;
    logic low_rd, high_rd, status_rd, slow, over, fail, event_out;
    logic alert_out, alert_oe, fault_out, fault_oe, force_on, corr_en;
    fsmd_mode_t fan_mode;
    logic [7:0] duty_reg, calc_duty, low_byte, high_byte, pwm_duty, lo, hi;
    logic [15:0] min_lim, max_lim, half_clks;
    logic [2:0] spin_time;
    int err_count, num_checks, cyc_count;
    fsmd_fan_model i_fsmd_fan_model (.core_clk(core_clk), .rst_n(rst_n),
        .half_clks(half_clks), .speed_pulse(pulse));
    fsmd_monitor #(.FAST_TICKS(8), .SLOW_TICKS(20), .MS_TICKS(1))
    i_fsmd_monitor (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .start_bit(start_bit), .speed_meas_enable(speed_meas_enable),
        .pulses_per_rev_select(pps), .fast_rate(fast_rate),
        .fan_power_type(fan_power_type), .fan_mode(fan_mode),
        .duty_cycle_register(duty_reg), .calc_duty(calc_duty),
        .min_speed_limit(min_lim), .max_speed_limit(max_lim),
        .fan_range_irq_enable(irq_en), .fault_pin_enable(fault_en),
        .spinup_disable(spin_dis), .spinup_time_field(spin_time),
        .speed_pulse(pulse), .period_low_rd(low_rd),
        .period_high_rd(high_rd), .status_rd(status_rd),
        .period_low_byte(low_byte), .period_high_byte(high_byte),
        .fan_slow_flag(slow), .overspeed_flag(over), .fan_failure(fail),
        .fan_range_event(event_out), .smb_alert_out(alert_out),
        .smb_alert_oe(alert_oe), .fault_pin_out(fault_out),
        .fault_pin_oe(fault_oe), .pwm_duty(pwm_duty),
        .pwm_force_on(force_on), .duty_correct_en(corr_en));
    // Clock of 40 ns period
    always #20 core_clk = !core_clk;
    // Hang guard
    always @(posedge core_clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == CYC_LIMIT) begin
            err_count++;
            $display("ERROR %0t run too long", $time);
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic fail_msg(input string msg);
        err_count++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic check_bit(input logic got, input logic exp, string msg);
        num_checks++;
        if (got !== exp) fail_msg(msg);
    endtask
    task automatic check_byte(input logic [7:0] got, exp, string msg);
        num_checks++;
        if (got !== exp) fail_msg(msg);
    endtask
    task automatic check_range(input logic [7:0] got, lo_b, hi_b);
        num_checks++;
        if ((got >= lo_b) !== 1'b1 || (got <= hi_b) !== 1'b1) begin
            fail_msg("period count out of range");
        end
    endtask
    // Low byte first, then high byte, sampled while frozen
    task automatic read_period(input logic [7:0] lo_b, hi_b);
        @(posedge core_clk) low_rd <= 1'b1;
        #1 lo = low_byte;
        @(posedge core_clk) low_rd <= 1'b0;
        @(posedge core_clk) high_rd <= 1'b1;
        #1 hi = high_byte;
        @(posedge core_clk) high_rd <= 1'b0;
        check_range(lo, lo_b, hi_b);
        check_byte(hi, 8'h00, "high byte");
    endtask
    task automatic read_status();
        @(posedge core_clk) status_rd <= 1'b1;
        @(posedge core_clk) status_rd <= 1'b0;
        #1;
    endtask
    task automatic t_reset();
        #1;
        check_byte(low_byte, 8'h00, "low byte at reset");
        check_bit(slow | over | fail, 1'b0, "flags at reset");
        check_bit(fault_oe, 1'b0, "fault pin at reset");
    endtask
    task automatic t_measure();
        @(posedge core_clk) start_bit <= 1'b1;
        speed_meas_enable <= 1'b1;
        repeat (SETTLE) @(posedge core_clk);
        read_period(8'h03, 8'h05);
        @(posedge core_clk) pps <= 1'b1;
        repeat (SETTLE) @(posedge core_clk);
        read_period(8'h07, 8'h09);
    endtask
    task automatic t_flags();
        @(posedge core_clk) min_lim <= 16'h0005;
        repeat (SETTLE) @(posedge core_clk);
        check_bit(slow, 1'b1, "slow flag not set");
        check_bit(alert_oe, 1'b1, "alert not pulled");
        read_status();
        check_bit(slow, 1'b0, "slow flag kept after read");
        repeat (SETTLE) @(posedge core_clk);
        check_bit(slow, 1'b1, "slow flag not reasserted");
        @(posedge core_clk) min_lim <= 16'hFFFF;
        max_lim <= 16'h001E;
        read_status();
        repeat (SETTLE) @(posedge core_clk);
        check_bit(over, 1'b1, "overspeed not set");
        read_status();
        repeat (SETTLE) @(posedge core_clk);
        check_bit(over, 1'b0, "overspeed reasserted");
        check_bit(alert_oe, 1'b0, "alert still pulled");
    endtask
    task automatic t_pwm_fan();
        @(posedge core_clk) fan_power_type <= 1'b0;
        duty_reg <= 8'h10;
        #1;
        check_byte(pwm_duty, DUTY_ZERO, "low duty not zeroed");
        check_bit(corr_en, 1'b1, "correction off");
        repeat (SETTLE) @(posedge core_clk);
        read_period(8'h07, 8'h09);
        // Pulse count changes with the switch to RPM mode, where low duty no longer skips updates, so measurements resume
        @(posedge core_clk) fan_mode <= FSMD_MODE_SW_RPM;
        pps <= 1'b0;
        #1;
        check_byte(pwm_duty, DUTY_MIN_30PCT, "duty not clamped");
        repeat (SETTLE) @(posedge core_clk);
        read_period(8'h03, 8'h05);
    endtask
    task automatic t_dc_fan();
        @(posedge core_clk) fan_power_type <= 1'b1;
        fan_mode <= FSMD_MODE_SW_DUTY;
        half_clks <= 16'd500;
        #1;
        check_byte(pwm_duty, 8'h10, "duty altered");
        check_bit(corr_en, 1'b0, "correction on");
        repeat (SETTLE) @(posedge core_clk);
        read_period(8'h07, 8'h09);
    endtask
    task automatic t_off();
        @(posedge core_clk) start_bit <= 1'b0;
        half_clks <= 16'd250;
        repeat (SETTLE) @(posedge core_clk);
        read_period(8'h07, 8'h09);
    endtask
    // Slow fan with spin-up enabled; monitor off later cuts the spin
    task automatic t_spin();
        @(posedge core_clk) min_lim <= 16'h0005;
        spin_dis <= 1'b0;
        repeat (SETTLE) @(posedge core_clk);
        check_bit(pwm_duty >= DUTY_SPIN_33PCT, 1'b1, "no ramp");
        check_bit(slow, 1'b1, "slow flag not set");
        check_bit(fail, 1'b0, "early failure");
        read_status();
        check_bit(slow, 1'b0, "slow detected in spin-up");
    endtask
    // Main sequence
    initial begin
        {core_clk, rst_n, start_bit, speed_meas_enable, pps} = 5'b00000;
        {low_rd, high_rd, status_rd, irq_en, fault_en} = 5'b00010;
        {clk_en, fast_rate, fan_power_type, spin_dis} = 4'b1111;
        fan_mode = FSMD_MODE_SW_DUTY;
        duty_reg = 8'h80;
        calc_duty = 8'h10;
        min_lim = 16'hFFFF;
        max_lim = 16'h0000;
        half_clks = 16'd250;
        spin_time = 3'h0;
        {err_count, num_checks, cyc_count} = '0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_measure();
        t_flags();
        t_pwm_fan();
        t_dc_fan();
        t_spin();
        t_off();
        give_verdict();
    end
endmodule
